// File: design/splr_port.sv
// Purpose: lockup detection and port reset recovery of a sata host port
// Assumes: rx events are same-clock pulses from the link layer; phy ready
//    is a pin and is synchronised here
// Notes: the soft reset path is deliberately ineffective once locked
//    but still drops a pending command while the link is healthy
//
// What this block does
// - on link lockup set interface fatal flag, status bit 27.
// - on link lockup also set link sequence diag, error bit 23.
// - fis then sync escape locks the link; pending command times out.
// - corrupted continue primitive in pio read locks link; command times out.
// - soft reset through command list does not clear a lockup.
// - register fis over eight dwords overflows fifo and locks controller.
`timescale 1ns/1ns
`default_nettype none
`include "splr_cfg.svh"
module splr_port
   import splr_pkg::*;
#(
   parameter int unsigned CMD_TIMEOUT_CYC = `SPLR_CMD_TIMEOUT_CYC
)
(
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // link and command side
   input wire splr_rx_s rx,
   input wire splr_cmd_s cmd,
   // status words, flags and store read data
   output logic [31:0] port_interrupt_status,
   output logic [31:0] port_error_register,
   output splr_stat_s stat,
   output logic [31:0] rx_dword
);
   typedef struct packed {
      logic [1:0] phy_sync;
      splr_link_e link;
      logic [`SPLR_FIFO_AW-1:0] rd_ptr;
      logic [31:0] timer;
      logic cmd_busy;
      logic [31:0] pis;
      logic [31:0] perr;
      splr_stat_s stat;
      logic [3:0] det_prev;
   } splr_state_s;

   splr_state_s st_r, st_nxt;
   logic [1:0] rst_sync_r;
   logic rst_n;
   logic fifo_ovf;
   logic fifo_flush;
   logic fifo_wr;
   logic [31:0] fifo_rd;
   logic comreset;
   logic lock_evt;

   // a strobe on the transition to 0x1, so a held value fires once
   function automatic logic det_edge(input logic [3:0] now,
                                     input logic [3:0] prev);
      return (now == `SPLR_DET_COMRESET) && (prev != `SPLR_DET_COMRESET);
   endfunction

   // both lock paths share this decode; keep them in step
   function automatic logic cont_fault(input splr_rx_s ev);
      return ev.pio_read && ev.cont_corrupt;
   endfunction

   function automatic logic is_locked(input splr_link_e state);
      return state == SPLR_LINK_LOCKED;
   endfunction

   assign rst_n = rst_sync_r[1];
   assign comreset = det_edge(cmd.detect_init_field, st_r.det_prev);
   // each register fis starts from an empty store, so only a single fis
   // longer than the store can overflow it
   assign fifo_flush = comreset
      || (rx.fis_start && st_r.link == SPLR_LINK_IDLE);
   assign fifo_wr = rx.fis_word && st_r.link == SPLR_LINK_RECV;

   splr_rx_fifo u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .flush(fifo_flush),
      .wr_en(fifo_wr),
      .wr_data(rx.fis_data),
      .rd_addr(st_r.rd_ptr),
      .rd_data(fifo_rd),
      .overflow(fifo_ovf)
   );

   always_comb begin
      st_nxt = st_r;
      lock_evt = 1'b0;
      st_nxt.phy_sync = {st_r.phy_sync[0], rx.phy_ready};
      st_nxt.det_prev = cmd.detect_init_field;
      st_nxt.stat.comreset_out = comreset;
      st_nxt.stat.cmd_complete = 1'b0;
      // free-running read pointer gives a rotating debug view of the store
      st_nxt.rd_ptr = st_r.rd_ptr + (`SPLR_FIFO_AW)'(1);
      // a locked port drops new commands
      if (cmd.cmd_issue && !is_locked(st_r.link)) begin
         st_nxt.cmd_busy = 1'b1;
         st_nxt.timer = '0;
      end
      unique case (st_r.link)
         SPLR_LINK_INIT: begin
            if (st_r.phy_sync[1]) begin
               st_nxt.link = SPLR_LINK_IDLE;
            end
         end
         SPLR_LINK_IDLE: begin
            if (rx.fis_start) begin
               st_nxt.link = SPLR_LINK_RECV;
            end else if (cont_fault(rx)) begin
               lock_evt = 1'b1;
            end
         end
         SPLR_LINK_RECV: begin
            if (rx.sync_escape) begin
               lock_evt = 1'b1;
            end else if (cont_fault(rx)) begin
               lock_evt = 1'b1;
               // overflow shows a cycle after the ninth word and is checked ahead of its end
            end else if (fifo_ovf) begin
               lock_evt = 1'b1;
            end else if (rx.fis_end) begin
               st_nxt.link = SPLR_CMD_DONE;
            end
         end
         SPLR_CMD_DONE: begin
            if (st_r.cmd_busy) begin
               st_nxt.stat.cmd_complete = 1'b1;
               st_nxt.cmd_busy = 1'b0;
            end
            st_nxt.link = SPLR_LINK_IDLE;
         end
         SPLR_LINK_LOCKED: begin
            // soft reset reaches a core that no longer listens
            st_nxt.link = SPLR_LINK_LOCKED;
         end
         default: begin
            // the spare state codes fall back to link start-up
            st_nxt.link = SPLR_LINK_INIT;
         end
      endcase
      // soft reset only helps a port that still listens
      if (cmd.soft_reset && !is_locked(st_r.link)) begin
         st_nxt.cmd_busy = 1'b0;
         st_nxt.timer = '0;
         if (st_r.link != SPLR_LINK_INIT) begin
            st_nxt.link = SPLR_LINK_IDLE;
         end
      end
      if (lock_evt) begin
         st_nxt.link = SPLR_LINK_LOCKED;
         st_nxt.pis[`SPLR_IFS_BIT] = 1'b1;
         st_nxt.perr[`SPLR_DIAG_BIT] = 1'b1;
      end
      // the timer only runs while locked; a healthy command has no deadline
      if (st_r.cmd_busy && is_locked(st_r.link)) begin
         if (st_r.timer == 32'(CMD_TIMEOUT_CYC - 1)) begin
            st_nxt.stat.cmd_timeout = 1'b1;
            st_nxt.cmd_busy = 1'b0;
         end else begin
            st_nxt.timer = st_r.timer + 32'h1;
         end
      end
      if (comreset) begin
         // flags stay set for software; link, command and timeout state are recovered
         st_nxt.link = SPLR_LINK_INIT;
         st_nxt.cmd_busy = 1'b0;
         st_nxt.timer = '0;
         st_nxt.stat.cmd_timeout = 1'b0;
      end
      st_nxt.stat.interface_fatal_flag = st_nxt.pis[`SPLR_IFS_BIT];
      st_nxt.stat.link_sequence_diag = st_nxt.perr[`SPLR_DIAG_BIT];
      st_nxt.stat.link_locked = is_locked(st_nxt.link);
   end

   // reset release synchroniser; kept outside the state struct because it
   // is the only register that sees the raw reset pin
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r.phy_sync <= 2'h0;
         st_r.link <= SPLR_LINK_INIT;
         st_r.rd_ptr <= '0;
         st_r.timer <= 32'h0;
         st_r.cmd_busy <= 1'b0;
         st_r.pis <= `SPLR_REG_RESET;
         st_r.perr <= `SPLR_REG_RESET;
         st_r.stat <= '0;
         st_r.det_prev <= `SPLR_DET_NONE;
      end else begin
         st_r.phy_sync <= st_nxt.phy_sync;
         st_r.link <= st_nxt.link;
         st_r.rd_ptr <= st_nxt.rd_ptr;
         st_r.timer <= st_nxt.timer;
         st_r.cmd_busy <= st_nxt.cmd_busy;
         st_r.pis <= st_nxt.pis;
         st_r.perr <= st_nxt.perr;
         st_r.stat <= st_nxt.stat;
         st_r.det_prev <= st_nxt.det_prev;
      end
   end

   assign port_interrupt_status = st_r.pis;
   assign port_error_register = st_r.perr;
   assign stat = st_r.stat;
   assign rx_dword = fifo_rd;
endmodule
`default_nettype wire

// File: design/splr_cfg.svh
// Purpose: constants for the sata port lockup recovery block
// Assumes: 250 MHz clock
// Notes: bit positions are within 32-bit status words
`ifndef SPLR_CFG_SVH
`define SPLR_CFG_SVH
`define SPLR_IFS_BIT 27
`define SPLR_DIAG_BIT 23
`define SPLR_DET_LSB 0
`define SPLR_DET_MSB 3
`define SPLR_DET_COMRESET 4'h1
`define SPLR_DET_NONE 4'h0
`define SPLR_FIFO_DEPTH 8
`define SPLR_FIFO_AW 3
`define SPLR_CMD_TIMEOUT_US 1000
`define SPLR_CMD_TIMEOUT_CYC (`SPLR_CMD_TIMEOUT_US * 250)
`define SPLR_REG_RESET 32'h0000_0000
`endif

// File: design/splr_pkg.sv
// Purpose: types for the sata port lockup recovery block
// Assumes: nothing
// Notes: state enum and carrier structs
package splr_pkg;
   typedef enum logic [2:0] {
      SPLR_LINK_INIT,
      SPLR_LINK_IDLE,
      SPLR_LINK_RECV,
      SPLR_LINK_LOCKED,
      SPLR_CMD_DONE
   } splr_link_e;

   // receive side events decoded by the link layer
   typedef struct packed {
      logic fis_start;
      logic fis_word;
      logic [31:0] fis_data;
      logic fis_end;
      logic sync_escape;
      logic cont_corrupt;
      logic pio_read;
      logic phy_ready;
   } splr_rx_s;

   // command side from the command list engine
   typedef struct packed {
      logic cmd_issue;
      logic soft_reset;
      logic [3:0] detect_init_field;
   } splr_cmd_s;

   typedef struct packed {
      logic interface_fatal_flag;
      logic link_sequence_diag;
      logic cmd_timeout;
      logic cmd_complete;
      logic link_locked;
      logic comreset_out;
   } splr_stat_s;
endpackage

// File: design/splr_rx_fifo.sv
// Purpose: eight dword receive store for register fis data
// Assumes: one write per cycle, reads registered
// Notes: overflow is reported, not blocked, as in the faulty core
`timescale 1ns/1ns
`default_nettype none
`include "splr_cfg.svh"
module splr_rx_fifo
   import splr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // control
   input wire logic flush,
   input wire logic wr_en,
   input wire logic [31:0] wr_data,
   input wire logic [`SPLR_FIFO_AW-1:0] rd_addr,
   // status
   output logic [31:0] rd_data,
   output logic overflow
);
   typedef struct packed {
      logic [`SPLR_FIFO_AW:0] count;
      logic [31:0] rd_data;
      logic overflow;
   } splr_fifo_s;
   logic [31:0] mem_r [`SPLR_FIFO_DEPTH];
   splr_fifo_s st_r, st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.rd_data = mem_r[rd_addr];
      if (flush) begin
         st_nxt.count = '0;
         st_nxt.overflow = 1'b0;
      end else if (wr_en) begin
         if (st_r.count == (`SPLR_FIFO_AW+1)'(`SPLR_FIFO_DEPTH)) begin
            st_nxt.overflow = 1'b1;
         end else begin
            st_nxt.count = st_r.count + (`SPLR_FIFO_AW+1)'(1);
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // storage has no reset; contents are invalid once count is cleared
   always_ff @(posedge clock) begin
      if (wr_en && !flush && st_r.count != (`SPLR_FIFO_AW+1)'(`SPLR_FIFO_DEPTH)) begin
         mem_r[st_r.count[`SPLR_FIFO_AW-1:0]] <= wr_data;
      end
   end

   assign rd_data = st_r.rd_data;
   assign overflow = st_r.overflow;
endmodule
`default_nettype wire

// File: verification/splr_port_checker.sv
// Purpose: assertions on lockup flags and port reset recovery
// Assumes: flags stay set until reset_n
// Notes: sees top module ports only
`timescale 1ns/1ns
`default_nettype none
module splr_port_checker
   import splr_pkg::*;
#(
   parameter int unsigned CMD_TIMEOUT_CYC = 16
)
(
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // watched ports
   input wire splr_cmd_s cmd,
   input wire logic [31:0] port_interrupt_status,
   input wire logic [31:0] port_error_register,
   input wire splr_stat_s stat
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic [3:0] det_r;
   // a port reset is the 0x1 edge, not the level
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         det_r <= 4'h0;
      end else begin
         det_r <= cmd.detect_init_field;
      end
   end
   wire logic det_edge = cmd.detect_init_field == 4'h1 && det_r != 4'h1;
   AST_LOCK_FLAGS: assert property ($rose(stat.link_locked) |->
      port_interrupt_status[27] && port_error_register[23])
      else $error("lock without both flags");
   AST_IFS_STICKY: assert property (port_interrupt_status[27] |=>
      port_interrupt_status[27]) else $error("fatal flag dropped");
   AST_DIAG_STICKY: assert property (port_error_register[23] |=>
      port_error_register[23]) else $error("diag flag dropped");
   AST_SOFT_NO_FIX: assert property (stat.link_locked &&
      cmd.soft_reset && !det_edge |=> stat.link_locked)
      else $error("soft reset cleared lock");
   AST_PORT_RST: assert property (det_edge |=> stat.comreset_out &&
      !stat.link_locked && !stat.cmd_timeout)
      else $error("port reset did not recover");
   AST_RST_PULSE: assert property (stat.comreset_out |=>
      !stat.comreset_out) else $error("comreset too long");
   AST_TMO_HOLD: assert property (stat.cmd_timeout && !det_edge |=>
      stat.cmd_timeout) else $error("timeout dropped");
   AST_NO_DONE: assert property (stat.link_locked |->
      !stat.cmd_complete) else $error("completion while locked");
   AST_MIRROR: assert property (
      port_interrupt_status[27] == stat.interface_fatal_flag &&
      port_error_register[23] == stat.link_sequence_diag)
      else $error("flag copies differ");
endmodule
bind splr_port splr_port_checker #(.CMD_TIMEOUT_CYC(CMD_TIMEOUT_CYC)) i_chk (
   .clock, .reset_n, .cmd, .port_interrupt_status, .port_error_register,
   .stat);
`default_nettype wire

// File: verification/splr_dev_model.sv
// Purpose: attached drive as seen by the port's receive side
// Assumes: events change 1 ns after the rising edge
// Notes: data lines show inverted data once released
`timescale 1ns/1ns
`default_nettype none
module splr_dev_model
   import splr_pkg::*;
(
   // clock
   input wire logic clock,
   // receive events toward the port
   output var splr_rx_s rx
);
   initial begin
      rx = '0;
      rx.phy_ready = 1'b1;
   end
   task automatic step;
      @(posedge clock);
      #1;
   endtask
   // n dwords, then a clean end or a sync escape
   task automatic fis(input int n, input bit esc);
      rx.fis_start = 1'b1;
      step;
      rx.fis_start = 1'b0;
      for (int i = 0; i < n; i++) begin
         rx.fis_word = 1'b1;
         rx.fis_data = 32'ha5a50000 + 32'(i);
         step;
      end
      rx.fis_word = 1'b0;
      rx.fis_data = ~rx.fis_data;
      rx.sync_escape = esc;
      rx.fis_end = !esc;
      step;
      rx.sync_escape = 1'b0;
      rx.fis_end = 1'b0;
   endtask
   task automatic pio_bad;
      rx.pio_read = 1'b1;
      rx.cont_corrupt = 1'b1;
      step;
      rx.cont_corrupt = 1'b0;
      rx.pio_read = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: verification/splr_port_test.sv
// Purpose: self-checking bench for port lockup recovery
// Assumes: timeout shortened to 16 cycles
// Notes: reset between scenarios so the sticky flags start clear
`timescale 1ns/1ns
`default_nettype none
module splr_port_test;
   import splr_pkg::*;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   splr_cmd_s cmd = '0;
   splr_rx_s rx;
   splr_stat_s stat;
   logic [31:0] pis;
   logic [31:0] per;
   logic [31:0] rxd;
   int failures = 0;
   int n_tests = 0;
   always #2 clock = ~clock;
   splr_port #(.CMD_TIMEOUT_CYC(16)) i_dut (.clock(clock),
      .reset_n(reset_n), .rx(rx), .cmd(cmd), .port_interrupt_status(pis),
      .port_error_register(per), .stat(stat), .rx_dword(rxd));
   splr_dev_model i_dev (.clock(clock), .rx(rx));
   task automatic step;
      @(posedge clock);
      #1;
   endtask
   task automatic chk(input logic c, input string m);
      n_tests++;
      if (c !== 1'b1) begin
         failures++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // bounded wait on one stat bit
   task automatic wait_bit(input int k, input string m);
      for (int i = 0; i < 60 && stat[k] !== 1'b1; i++) step;
      chk(stat[k], m);
      if (stat[k] !== 1'b1) wrap_up;
   endtask
   task automatic restart;
      reset_n = 1'b0;
      repeat (4) step;
      reset_n = 1'b1;
      repeat (8) step;
      chk(pis[27] === 1'b0 && per[23] === 1'b0, "flags at reset");
   endtask
   task automatic issue;
      cmd.cmd_issue = 1'b1;
      step;
      cmd.cmd_issue = 1'b0;
   endtask
   // locked port: flags, timeout, soft reset refused, port reset
   task automatic recover;
      wait_bit(1, "no lock");
      chk(pis[27] === 1'b1 && per[23] === 1'b1, "flags");
      wait_bit(3, "no timeout");
      cmd.soft_reset = 1'b1;
      step;
      cmd.soft_reset = 1'b0;
      repeat (3) step;
      chk(stat.link_locked, "soft reset freed");
      cmd.detect_init_field = 4'h1;
      wait_bit(0, "no comreset");
      chk(!stat.link_locked && !stat.cmd_timeout, "still locked");
      cmd.detect_init_field = 4'h0;
      repeat (6) step;
      issue;
      i_dev.fis(3, 1'b0);
      wait_bit(2, "no completion after recovery");
   endtask
   task automatic sc_escape;
      restart;
      issue;
      i_dev.fis(2, 1'b1);
      recover;
   endtask
   task automatic sc_cont;
      restart;
      // a healthy port takes a soft reset and drops the pending command
      issue;
      cmd.soft_reset = 1'b1;
      step;
      cmd.soft_reset = 1'b0;
      i_dev.fis(1, 1'b0);
      for (int i = 0; i < 4; i++) begin
         step;
         chk(stat.cmd_complete === 1'b0, "soft reset kept command");
      end
      issue;
      i_dev.pio_bad;
      recover;
   endtask
   task automatic sc_oversize;
      logic [31:0] sum;
      restart;
      // two full-size fis in a row: the store must start empty for each
      repeat (2) begin
         issue;
         i_dev.fis(8, 1'b0);
         wait_bit(2, "eight dwords failed");
         chk(!stat.link_locked && pis[27] === 1'b0, "eight locked");
      end
      // the rotating read pointer visits all eight words in eight cycles
      sum = '0;
      for (int i = 0; i < 8; i++) begin
         sum = sum + rxd;
         step;
      end
      chk(sum === 32'h8 * 32'ha5a5_0000 + 32'h1c, "stored words");
      issue;
      i_dev.fis(9, 1'b0);
      recover;
   endtask
   initial begin
      sc_escape;
      sc_cont;
      sc_oversize;
      wrap_up;
   end
endmodule
`default_nettype wire
